// ---- shared/adcc_pkg.sv ----
// Function
// - a conversion end sets done flag bit 7 of 0x11 until software writes it zero, reset 0.
// - bit 6 of register 0x11 is a read/write enable for the end-of-conversion interrupt, reset 0.
// - converter clock is instruction clock over 16, 8, 1 or 2 for codes 00 to 11, reset 00.
// - result bits 3 to 0 read back as bits 3 to 0 of register 0x11 and ignore writes.
// - result bits 11 to 4 read back from read-only register 0x12, which resets to zero.
// - bit 7 of 0x13 (reset 0) selects the external pin when one, else the internal level.
// - internal reference code 11 is the supply, 10 is 4V, 01 is 3V, 00 is 2V, reset 11.
// - the sampling pulse lasts 1, 2, 4 or 8 converter clocks for codes 00 to 11, reset 10.
// - resolution code 00 is 8-bit, 01 is 10-bit, 1x is 12-bit, reset 10.
// - one analog-only bit per analog pin, five on port A and six on port B, in 0x16 and 0x14.
// - a five-bit trim with a sign bit (one adds, zero subtracts) offsets the data, reset 0.
// - writing one to the mode register's start bit, with the enable bit also one, while idle starts a conversion; the bit reads zero.
// - read-only end-of-conversion bit is one with a valid result, zero while busy, reset one.
// - channel codes 0000 to 1010 select pins, 1011 a quarter of the supply and 1100 ground.
// - the converter runs only while enabled; all channels are off while global enable is zero.
package adcc_pkg;

	localparam int RES_W = 12;

	localparam logic [7:0] ADDR_MODE  = 8'h10;
	localparam logic [7:0] ADDR_FLAG  = 8'h11;
	localparam logic [7:0] ADDR_RESH  = 8'h12;
	localparam logic [7:0] ADDR_REF   = 8'h13;
	localparam logic [7:0] ADDR_SAMP  = 8'h14;
	localparam logic [7:0] ADDR_PIN   = 8'h16;
	localparam logic [7:0] ADDR_TRIM  = 8'h17;
	localparam logic [7:0] ADDR_STAT  = 8'h20;
	localparam logic [7:0] ADDR_MASK  = 8'h21;

	localparam int MODE_EN_BIT    = 7;
	localparam int MODE_START_BIT = 6;
	localparam int MODE_EOC_BIT   = 5;
	localparam int MODE_GCH_BIT   = 4;
	localparam int FLAG_DONE_BIT  = 7;
	localparam int FLAG_IE_BIT    = 6;
	localparam int REF_EXT_BIT    = 7;
	localparam int TRIM_SIGN_BIT  = 5;
	localparam int STAT_DONE_BIT  = 0;
	localparam int STAT_REFUSE_BIT = 1;

	localparam logic [1:0] RST_CLKDIV = 2'h0;
	localparam logic [1:0] RST_REFLVL = 2'h3;
	localparam logic [1:0] RST_SAMPW  = 2'h2;
	localparam logic [1:0] RST_RES    = 2'h2;
	localparam logic       RST_EOC    = 1'h1;

	localparam logic [3:0] BIT_TICKS   = 4'h4;
	localparam logic [3:0] CH_LAST     = 4'hC;
	localparam logic [RES_W-1:0] RES_MSB = 12'h800;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} adcc_req_t;

	typedef struct packed {
		logic             converter_enable;
		logic             channel_connect;
		logic [3:0]       input_channel_select;
		logic             external_reference_select;
		logic [1:0]       internal_reference_level;
		logic             sample_hold;
		logic [RES_W-1:0] trial_code;
		logic [4:0]       porta_analog_only;
		logic [5:0]       portb_analog_only;
	} adcc_analog_t;

	// cycles per converter clock, minus one
	function automatic logic [3:0] div_terminal(input logic [1:0] sel);
		unique case (sel)
			2'h0: div_terminal = 4'hF;
			2'h1: div_terminal = 4'h7;
			2'h2: div_terminal = 4'h0;
			2'h3: div_terminal = 4'h1;
		endcase
	endfunction

	function automatic logic [3:0] sample_ticks(input logic [1:0] sel);
		unique case (sel)
			2'h0: sample_ticks = 4'h1;
			2'h1: sample_ticks = 4'h2;
			2'h2: sample_ticks = 4'h4;
			2'h3: sample_ticks = 4'h8;
		endcase
	endfunction

	function automatic logic [RES_W-1:0] res_mask(input logic [1:0] sel);
		unique case (sel)
			2'h0:    res_mask = 12'hFF0;
			2'h1:    res_mask = 12'hFFC;
			default: res_mask = 12'hFFF;
		endcase
	endfunction

endpackage

// ---- rtl/adcc_clkdiv.sv ----
`timescale 1ns/1ps
module adcc_clkdiv
	import adcc_pkg::*;
(
	input  wire logic       clk,
	input  wire logic       resetn,
	input  wire logic       run,
	input  wire logic [1:0] div_sel,
	output logic            tick
);
	logic [3:0] cnt;

	// restarting at each conversion keeps the first converter clock a full period long
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt <= 4'h0;
		end else if (!run || cnt >= div_terminal(div_sel)) begin
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end

	assign tick = run && (cnt >= div_terminal(div_sel));

endmodule

// ---- rtl/adcc_top.sv ----
// Strobed register access was decided locally.
`timescale 1ns/1ps
module adcc_top
	import adcc_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   resetn,
	input  adcc_req_t   req,
	output logic [7:0]  rdata,
	input  wire logic   comparator_in,
	output adcc_analog_t analog,
	output logic        irq
);
	typedef enum logic [1:0] {ST_IDLE, ST_SAMPLE, ST_CONVERT, ST_FINISH} adcc_state_t;

	adcc_state_t      state;
	logic             conv_en;
	logic             gch_en;
	logic [3:0]       chan;
	logic             eoc;
	logic             done_flag;
	logic             irq_en;
	logic [1:0]       clkdiv;
	logic [RES_W-1:0] result;
	logic             ext_ref;
	logic [1:0]       ref_lvl;
	logic [1:0]       samp_w;
	logic [1:0]       res_sel;
	logic [4:0]       porta_only;
	logic [5:0]       portb_only;
	logic             trim_sign;
	logic [4:0]       trim_mag;
	logic [1:0]       stat;
	logic [1:0]       mask;
	logic [RES_W-1:0] sar;
	logic [RES_W-1:0] trial_bit;
	logic [3:0]       tick_cnt;
	logic             cmp_s1;
	logic             cmp_s2;
	logic             cmp_s3;
	logic             cmp_q;
	logic             cmp_now;
	logic             tick;
	logic             start_req;
	logic             accept;
	logic             refused;
	logic             done_evt;
	logic [12:0]      trim_sum;
	logic [RES_W-1:0] trimmed;
	logic [7:0]       next_rdata;

	function automatic logic wr_at(input adcc_req_t r, input logic [7:0] a);
		wr_at = r.wr && (r.addr == a);
	endfunction

	assign start_req = wr_at(req, ADDR_MODE) && req.wdata[MODE_START_BIT];
	assign accept    = start_req && req.wdata[MODE_EN_BIT] && (state == ST_IDLE);
	assign refused   = start_req && !accept;
	assign done_evt  = (state == ST_FINISH);
	// the level the synchroniser is about to take, so divide by 1 sees the new trial in time
	assign cmp_now   = (cmp_s2 == cmp_s3) ? cmp_s3 : cmp_q;

	adcc_clkdiv u_div (
		.clk     (clk),
		.resetn  (resetn),
		.run     (state == ST_SAMPLE || state == ST_CONVERT),
		.div_sel (clkdiv),
		.tick    (tick)
	);

	// comparator is analog; s1 feeds only s2, a level counts once s2 and s3 agree
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cmp_s1 <= 1'b0;
			cmp_s2 <= 1'b0;
			cmp_s3 <= 1'b0;
			cmp_q  <= 1'b0;
		end else begin
			cmp_s1 <= comparator_in;
			cmp_s2 <= cmp_s1;
			cmp_s3 <= cmp_s2;
			if (cmp_s2 == cmp_s3) begin
				cmp_q <= cmp_s3;
			end
		end
	end

	// mode register
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			conv_en <= 1'b0;
			gch_en  <= 1'b0;
			chan    <= 4'h0;
		end else if (wr_at(req, ADDR_MODE)) begin
			conv_en <= req.wdata[MODE_EN_BIT];
			gch_en  <= req.wdata[MODE_GCH_BIT];
			chan    <= req.wdata[3:0];
		end
	end

	// conversion sequencer; a bit is decided on its fourth converter clock
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			state     <= ST_IDLE;
			sar       <= '0;
			trial_bit <= '0;
			tick_cnt  <= 4'h0;
		end else if (!conv_en && state != ST_IDLE) begin
			state <= ST_IDLE;
		end else begin
			unique case (state)
				ST_IDLE: begin
					if (accept) begin
						state    <= ST_SAMPLE;
						tick_cnt <= 4'h0;
						sar      <= '0;
					end
				end
				ST_SAMPLE: begin
					if (tick) begin
						if (tick_cnt == sample_ticks(samp_w) - 4'h1) begin
							state     <= ST_CONVERT;
							tick_cnt  <= 4'h0;
							sar       <= RES_MSB;
							trial_bit <= RES_MSB;
						end else begin
							tick_cnt <= tick_cnt + 4'h1;
						end
					end
				end
				ST_CONVERT: begin
					if (tick) begin
						if (tick_cnt == BIT_TICKS - 4'h1) begin
							tick_cnt <= 4'h0;
							// comparator high: input at or above the trial, keep the bit
							if (((trial_bit >> 1) & res_mask(res_sel)) == '0) begin
								sar   <= cmp_now ? sar : (sar & ~trial_bit);
								state <= ST_FINISH;
							end else begin
								sar       <= (cmp_now ? sar : (sar & ~trial_bit)) | (trial_bit >> 1);
								trial_bit <= trial_bit >> 1;
							end
						end else begin
							tick_cnt <= tick_cnt + 4'h1;
						end
					end
				end
				ST_FINISH: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// trim counts in 12-bit steps and saturates at both ends
	always_comb begin
		if (trim_sign) begin
			trim_sum = {1'b0, sar} + {8'h00, trim_mag};
			trimmed  = trim_sum[12] ? 12'hFFF : trim_sum[11:0];
		end else begin
			trim_sum = {1'b0, sar} - {8'h00, trim_mag};
			trimmed  = trim_sum[12] ? 12'h000 : trim_sum[11:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			result <= '0;
		end else if (done_evt) begin
			result <= trimmed & res_mask(res_sel);
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			eoc <= RST_EOC;
		end else if (accept) begin
			eoc <= 1'b0;
		end else if (done_evt || (!conv_en && state != ST_IDLE)) begin
			eoc <= 1'b1;
		end
	end

	// flag: a finish in the same cycle as a clearing write wins
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			done_flag <= 1'b0;
			irq_en    <= 1'b0;
			clkdiv    <= RST_CLKDIV;
		end else begin
			if (done_evt) begin
				done_flag <= 1'b1;
			end else if (wr_at(req, ADDR_FLAG) && !req.wdata[FLAG_DONE_BIT]) begin
				done_flag <= 1'b0;
			end
			if (wr_at(req, ADDR_FLAG)) begin
				irq_en <= req.wdata[FLAG_IE_BIT];
				clkdiv <= req.wdata[5:4];
			end
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			ext_ref <= 1'b0;
			ref_lvl <= RST_REFLVL;
		end else if (wr_at(req, ADDR_REF)) begin
			ext_ref <= req.wdata[REF_EXT_BIT];
			ref_lvl <= req.wdata[1:0];
		end
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			samp_w     <= RST_SAMPW;
			res_sel    <= RST_RES;
			porta_only <= 5'h00;
			portb_only <= 6'h00;
			trim_sign  <= 1'b0;
			trim_mag   <= 5'h00;
		end else begin
			if (wr_at(req, ADDR_SAMP)) begin
				portb_only[5:3] <= req.wdata[6:4];
				samp_w          <= req.wdata[3:2];
				res_sel         <= req.wdata[1:0];
			end
			if (wr_at(req, ADDR_PIN)) begin
				portb_only[2:0] <= req.wdata[7:5];
				porta_only      <= req.wdata[4:0];
			end
			if (wr_at(req, ADDR_TRIM)) begin
				trim_sign <= req.wdata[TRIM_SIGN_BIT];
				trim_mag  <= req.wdata[4:0];
			end
		end
	end

	// interrupt status, write one to clear; a new event wins over the clear
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			stat <= 2'h0;
			mask <= 2'h0;
		end else begin
			stat <= (stat & ~(wr_at(req, ADDR_STAT) ? req.wdata[1:0] : 2'h0))
				| {refused, done_evt};
			if (wr_at(req, ADDR_MASK)) begin
				mask <= req.wdata[1:0];
			end
		end
	end

	assign irq = (|(stat & mask)) || (done_flag && irq_en);

	always_comb begin
		unique case (req.addr)
			ADDR_MODE: next_rdata = {conv_en, 1'b0, eoc, gch_en, chan};
			ADDR_FLAG: next_rdata = {done_flag, irq_en, clkdiv, result[3:0]};
			ADDR_RESH: next_rdata = result[11:4];
			ADDR_REF:  next_rdata = {ext_ref, 5'h00, ref_lvl};
			ADDR_SAMP: next_rdata = {1'b0, portb_only[5:3], samp_w, res_sel};
			ADDR_PIN:  next_rdata = {portb_only[2:0], porta_only};
			ADDR_TRIM: next_rdata = {2'h0, trim_sign, trim_mag};
			ADDR_STAT: next_rdata = {6'h00, stat};
			ADDR_MASK: next_rdata = {6'h00, mask};
			default:   next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			rdata <= 8'h00;
		end else begin
			rdata <= req.rd ? next_rdata : 8'h00;
		end
	end

	always_comb begin
		analog.converter_enable          = conv_en;
		analog.channel_connect           = gch_en && (chan <= CH_LAST);
		analog.input_channel_select      = chan;
		analog.external_reference_select = ext_ref;
		analog.internal_reference_level  = ref_lvl;
		analog.sample_hold               = (state == ST_SAMPLE);
		analog.trial_code                = sar;
		analog.porta_analog_only         = porta_only;
		analog.portb_analog_only         = portb_only;
	end

	// helper counters watched only by the checks below
	logic [3:0] chk_hold;
	logic [4:0] chk_gap;
	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			chk_hold <= 4'h0;
			chk_gap  <= 5'h00;
		end else begin
			chk_hold <= (state != ST_SAMPLE) ? 4'h0 : (tick ? chk_hold + 4'h1 : chk_hold);
			chk_gap  <= (tick || state == ST_IDLE || state == ST_FINISH) ? 5'h00 : chk_gap + 5'h01;
		end
	end

	sequence s_start;
		accept;
	endsequence

	sequence s_finish;
		done_evt;
	endsequence

	a_flag_on_done: assert property (@(posedge clk) disable iff (!resetn)
		s_finish |=> done_flag) else $error("done flag not set after conversion end");
	a_flag_write_clear: assert property (@(posedge clk) disable iff (!resetn)
		wr_at(req, ADDR_FLAG) && !req.wdata[7] && !done_evt |=> !done_flag)
		else $error("done flag not cleared by writing zero");
	a_irq_enable: assert property (@(posedge clk) disable iff (!resetn)
		done_flag && irq_en |-> irq) else $error("enabled done flag did not raise irq");
	a_tick_period: assert property (@(posedge clk) disable iff (!resetn)
		tick && $stable(clkdiv) |-> chk_gap == 5'(div_terminal(clkdiv)))
		else $error("converter clock spacing wrong");
	a_result_update: assert property (@(posedge clk) disable iff (!resetn)
		$changed(result) |-> $past(done_evt)) else $error("result changed outside conversion end");
	a_high_read: assert property (@(posedge clk) disable iff (!resetn)
		req.rd && req.addr == ADDR_RESH && !done_evt |=> rdata == result[11:4])
		else $error("high result read wrong");
	a_sample_len: assert property (@(posedge clk) disable iff (!resetn)
		state == ST_SAMPLE ##1 state == ST_CONVERT |-> $past(chk_hold) + 4'h1
			== sample_ticks($past(samp_w))) else $error("sampling pulse length wrong");
	a_low_bits_zero: assert property (@(posedge clk) disable iff (!resetn)
		s_finish and res_sel == 2'h0 |=> result[3:0] == 4'h0)
		else $error("8-bit result has low bits set");
	a_start_reads_zero: assert property (@(posedge clk) disable iff (!resetn)
		req.rd && req.addr == ADDR_MODE |=> !rdata[6]) else $error("start bit read as one");
	a_eoc_busy: assert property (@(posedge clk) disable iff (!resetn)
		s_start |=> !eoc until (state == ST_IDLE)) else $error("eoc high while busy");
	a_disabled_idle: assert property (@(posedge clk) disable iff (!resetn)
		!conv_en && !accept |=> state == ST_IDLE) else $error("converter runs while disabled");
	a_channel_off: assert property (@(posedge clk) disable iff (!resetn)
		!gch_en |-> !analog.channel_connect) else $error("channel connected while disabled");

endmodule

// ---- tb/adcc_top_tb.sv ----
`timescale 1ns/1ps
module adcc_top_tb;
	import adcc_pkg::*;

	logic         clk;
	logic         resetn;
	adcc_req_t    req;
	logic [7:0]   rdata;
	logic         comparator_in;
	adcc_analog_t analog;
	logic         irq;
	logic [11:0]  vin;
	int           num_errors;
	int           n_checks;

	localparam logic [7:0] RST_A [10] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17,
		8'h20, 8'h21, 8'h30};
	localparam logic [7:0] RST_D [10] = '{8'h20, 8'h00, 8'h00, 8'h03, 8'h0A, 8'h00, 8'h00,
		8'h00, 8'h00, 8'h00};
	localparam logic [7:0] WR_A [7] = '{8'h11, 8'h12, 8'h13, 8'h14, 8'h16, 8'h17, 8'h30};
	localparam logic [7:0] WR_D [7] = '{8'h70, 8'h00, 8'h83, 8'h7F, 8'hFF, 8'h3F, 8'h00};

	adcc_top dut (
		.clk           (clk),
		.resetn        (resetn),
		.req           (req),
		.rdata         (rdata),
		.comparator_in (comparator_in),
		.analog        (analog),
		.irq           (irq)
	);

	// ideal comparator against a fixed input level
	assign comparator_in = (vin >= analog.trial_code);

	task automatic chk(input logic [11:0] g, input logic [11:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			num_errors++;
			$display("mismatch at %0t ns: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge clk);
		req.wr <= 1'b0;
	endtask

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge clk);
		req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge clk);
		req.rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string m);
		logic [7:0] d;
		rd(a, d);
		chk(d, e, m);
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic conv(input logic [1:0] ds, input logic [1:0] ss, input logic [1:0] rs,
			input logic [5:0] tr);
		int          div;
		int          tk;
		int          n;
		int          s;
		logic [11:0] m;
		logic [11:0] e;
		logic [7:0]  d;
		div = (ds == 2'h0) ? 16 : (ds == 2'h1) ? 8 : (ds == 2'h2) ? 1 : 2;
		tk = 1 << ss;
		m = (rs == 2'h0) ? 12'hFF0 : (rs == 2'h1) ? 12'hFFC : 12'hFFF;
		s = int'(vin & m);
		s = tr[5] ? s + int'(tr[4:0]) : s - int'(tr[4:0]);
		s = (s < 0) ? 0 : (s > 4095) ? 4095 : s;
		e = 12'(s) & m;
		wr(ADDR_FLAG, {2'b01, ds, 4'hF});
		wr(ADDR_SAMP, {4'h0, ss, rs});
		wr(ADDR_TRIM, {2'b00, tr});
		wr(ADDR_MODE, 8'hD3);
		#1;
		n = 0;
		while (analog.sample_hold === 1'b1 && n < 300) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(12'(n >= (tk - 1) * div + 1 && n <= tk * div + 1), 12'h001, "sample width");
		chk(analog.converter_enable, 12'h001, "enable out");
		rchk(ADDR_MODE, 8'h93, "busy mode");
		// a second start while busy must be refused
		wr(ADDR_MODE, 8'hD3);
		n = 0;
		d = 8'h00;
		while (d[MODE_EOC_BIT] !== 1'b1 && n < 1000) begin
			rd(ADDR_MODE, d);
			n++;
		end
		chk(12'(n < 1000), 12'h001, "conversion end");
		rchk(ADDR_RESH, e[11:4], "result high");
		rchk(ADDR_FLAG, {2'b11, ds, e[3:0]}, "flag and low");
		chk(irq, 12'h001, "irq enabled");
		rchk(ADDR_STAT, 8'h03, "status");
		wr(ADDR_STAT, 8'h03);
		wr(ADDR_FLAG, {2'b10, ds, 4'h0});
		rchk(ADDR_FLAG, {2'b10, ds, e[3:0]}, "flag kept");
		chk(irq, 12'h000, "irq disabled");
		wr(ADDR_FLAG, {2'b00, ds, 4'h0});
		rchk(ADDR_FLAG, {2'b00, ds, e[3:0]}, "flag cleared");
		rchk(ADDR_STAT, 8'h00, "status cleared");
	endtask

	initial begin
		clk = 1'b0;
		forever #12.5 clk = ~clk;
	end

	// the slowest conversion is under a thousand cycles
	initial begin
		repeat (30000) @(posedge clk);
		num_errors++;
		end_of_test();
	end

	initial begin
		resetn = 1'b0;
		req = '0;
		vin = 12'hA5C;
		num_errors = 0;
		n_checks = 0;
		repeat (4) @(posedge clk);
		resetn <= 1'b1;
		for (int i = 0; i < 10; i++) begin
			rchk(RST_A[i], RST_D[i], "reset value");
		end
		for (int i = 0; i < 7; i++) begin
			wr(WR_A[i], 8'hFF);
			rchk(WR_A[i], WR_D[i], "readback");
		end
		chk(irq, 12'h000, "irq idle");
		chk(analog.external_reference_select, 12'h001, "ext ref");
		wr(ADDR_PIN, 8'hA5);
		#1;
		chk(analog.porta_analog_only, 12'h005, "port a pins");
		chk(analog.portb_analog_only, 12'h03D, "port b pins");
		for (int l = 0; l < 4; l++) begin
			wr(ADDR_REF, {6'h00, 2'(l)});
			#1;
			chk(analog.internal_reference_level, 12'(l), "ref level");
			chk(analog.external_reference_select, 12'h000, "int ref");
		end
		for (int i = 0; i < 32; i++) begin
			wr(ADDR_MODE, {3'b000, 5'(i)});
			#1;
			chk(analog.channel_connect, 12'(i >= 16 && i <= 28), "connect");
			chk(analog.input_channel_select, 12'(i % 16), "channel");
			chk(analog.converter_enable, 12'h000, "disabled");
		end
		wr(ADDR_MASK, 8'h02);
		wr(ADDR_MODE, 8'h50);
		rchk(ADDR_MODE, 8'h30, "refused start");
		rchk(ADDR_STAT, 8'h02, "refused status");
		chk(irq, 12'h001, "irq unmasked");
		wr(ADDR_STAT, 8'h02);
		rchk(ADDR_STAT, 8'h00, "status clear");
		chk(irq, 12'h000, "irq cleared");
		wr(ADDR_MASK, 8'h00);
		conv(2'h0, 2'h2, 2'h3, 6'h00);
		conv(2'h1, 2'h1, 2'h0, 6'h25);
		conv(2'h3, 2'h3, 2'h1, 6'h1F);
		conv(2'h2, 2'h0, 2'h2, 6'h3F);
		// clearing the enable mid-conversion aborts, keeps the result and sets no flag
		wr(ADDR_MODE, 8'hD3);
		wr(ADDR_MODE, 8'h13);
		rchk(ADDR_MODE, 8'h33, "abort");
		rchk(ADDR_RESH, 8'hA7, "result kept");
		rchk(ADDR_FLAG, 8'h2B, "no flag on abort");
		rchk(ADDR_STAT, 8'h00, "no status on abort");
		end_of_test();
	end
endmodule
